// ===== hw/charger_protect_consts.vh
// constants shared by the charger input protection control core
`ifndef CHARGER_PROTECT_CONSTS_VH
`define CHARGER_PROTECT_CONSTS_VH

// ----------------------------------------------------------------
// clock and timing (times in microseconds)
// ----------------------------------------------------------------
`define CLK_MHZ            100
`define PGOOD_DGL_US       100
`define OVP_REC_DGL_US     100
`define OCP_BLANK_US       5
`define OCP_REC_US         100

// ----------------------------------------------------------------
// fault counting
// ----------------------------------------------------------------
`define FAULT_LIMIT        4'hf
`define FAULT_CNT_RESET    4'h0

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_COUNT          8'h08

// ctrl fields
`define CTRL_CLR_BIT       0

// bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== hw/charger_input_protection_ctrl.v
// control core of a charger front-end protection block
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "charger_protect_consts.vh"

module charger_input_protection_ctrl #(
    parameter ADDR_WIDTH   = 8,
    parameter TIMER_WIDTH  = 32,
    parameter PGOOD_CYCLES  = `PGOOD_DGL_US * `CLK_MHZ,
    parameter OVPREC_CYCLES = `OVP_REC_DGL_US * `CLK_MHZ,
    parameter BLANK_CYCLES  = `OCP_BLANK_US * `CLK_MHZ,
    parameter OCPREC_CYCLES = `OCP_REC_US * `CLK_MHZ
) (
    // clock and reset
    input  wire                  ref_clk,
    input  wire                  reset_n,
    // axi4-lite write address
    input  wire [ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire                  s_axi_awvalid,
    output wire                  s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output wire                  s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    // axi4-lite read address
    input  wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire                  s_axi_arvalid,
    output wire                  s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]           s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready,
    // comparator flags from the analog front end
    input  wire                  inUnderVolt,
    input  wire                  inOverVolt,
    input  wire                  inOverCurrent,
    input  wire                  batOverVolt,
    input  wire                  overTemp,
    // host enable, active low
    input  wire                  enable_n,
    // pass switch commands
    output reg                   passSwitchOn,
    output reg                   softStartReq,
    output reg                   softStopReq,
    output reg                   currentLimitHold,
    // open-drain fault indication
    output wire                  faultOut,
    output reg                   faultOe
);

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam S_DOWN   = 3'h0;
    localparam S_PGOOD  = 3'h1;
    localparam S_OFF    = 3'h2;
    localparam S_ON     = 3'h3;
    localparam S_OVP    = 3'h4;
    localparam S_OCPREC = 3'h5;

    localparam [TIMER_WIDTH-1:0] PGOOD_LAST  = PGOOD_CYCLES - 1;
    localparam [TIMER_WIDTH-1:0] OVPREC_LAST = OVPREC_CYCLES - 1;
    localparam [TIMER_WIDTH-1:0] BLANK_LAST  = BLANK_CYCLES - 1;
    localparam [TIMER_WIDTH-1:0] OCPREC_LAST = OCPREC_CYCLES - 1;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    reg rstMeta_reg;
    reg rstSync_n;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_reg <= 1'b0;
            rstSync_n   <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_n   <= rstMeta_reg;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers: a change counts once stages two and three agree
    // ------------------------------------------------------------
    wire [5:0] pinRaw;
    reg  [5:0] pinS1_reg;
    reg  [5:0] pinS2_reg;
    reg  [5:0] pinS3_reg;
    reg  [5:0] pinFilt_reg;
    wire [5:0] pinAgree;

    assign pinRaw   = {enable_n, overTemp, batOverVolt, inOverCurrent,
                       inOverVolt, inUnderVolt};
    assign pinAgree = ~(pinS2_reg ^ pinS3_reg);

    // filtered pins start as "under lockout" and "enabled"
    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pinS1_reg   <= 6'h01;
            pinS2_reg   <= 6'h01;
            pinS3_reg   <= 6'h01;
            pinFilt_reg <= 6'h01;
        end else begin
            pinS1_reg   <= pinRaw;
            pinS2_reg   <= pinS1_reg;
            pinS3_reg   <= pinS2_reg;
            pinFilt_reg <= (pinS3_reg & pinAgree) | (pinFilt_reg & ~pinAgree);
        end
    end

    wire uvlo    = pinFilt_reg[0];
    wire ovpF    = pinFilt_reg[1];
    wire ocpF    = pinFilt_reg[2];
    wire batF    = pinFilt_reg[3];
    wire otF     = pinFilt_reg[4];
    // floating pin is pulled down, so low means enabled
    wire enabled = ~pinFilt_reg[5];

    // ------------------------------------------------------------
    // protection sequencer
    // ------------------------------------------------------------
    reg [2:0]             state_reg;
    reg [TIMER_WIDTH-1:0] timer_reg;
    reg [3:0]             ocpCnt_reg;
    reg [3:0]             batCnt_reg;
    reg                   enPrev_reg;
    reg                   swClear_reg;

    wire locked    = (ocpCnt_reg == `FAULT_LIMIT) ||
                     (batCnt_reg == `FAULT_LIMIT);
    wire safe      = ~ovpF & ~batF & ~otF;
    wire clrCounts = (enabled & ~enPrev_reg) | swClear_reg;

    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_reg        <= S_DOWN;
            timer_reg        <= {TIMER_WIDTH{1'b0}};
            ocpCnt_reg       <= `FAULT_CNT_RESET;
            batCnt_reg       <= `FAULT_CNT_RESET;
            enPrev_reg       <= 1'b1;
            passSwitchOn     <= 1'b0;
            softStartReq     <= 1'b0;
            softStopReq      <= 1'b0;
            currentLimitHold <= 1'b0;
        end else if (uvlo) begin
            // power-down; everything cleared while below lockout
            state_reg        <= S_DOWN;
            timer_reg        <= {TIMER_WIDTH{1'b0}};
            ocpCnt_reg       <= `FAULT_CNT_RESET;
            batCnt_reg       <= `FAULT_CNT_RESET;
            enPrev_reg       <= 1'b1;
            passSwitchOn     <= 1'b0;
            softStartReq     <= 1'b0;
            softStopReq      <= 1'b0;
            currentLimitHold <= 1'b0;
        end else begin
            enPrev_reg       <= enabled;
            softStartReq     <= 1'b0;
            softStopReq      <= 1'b0;
            currentLimitHold <= 1'b0;
            // clear counters; a same-cycle increment below wins
            if (clrCounts) begin
                ocpCnt_reg <= `FAULT_CNT_RESET;
                batCnt_reg <= `FAULT_CNT_RESET;
            end
            case (state_reg)
                S_DOWN: begin
                    state_reg <= S_PGOOD;
                    timer_reg <= {TIMER_WIDTH{1'b0}};
                end
                S_PGOOD: begin
                    if (timer_reg >= PGOOD_LAST) begin
                        timer_reg <= {TIMER_WIDTH{1'b0}};
                        if (ovpF)
                            state_reg <= S_OVP;
                        else
                            state_reg <= S_OFF;
                    end else begin
                        timer_reg <= timer_reg + 1'b1;
                    end
                end
                S_OFF: begin
                    timer_reg <= {TIMER_WIDTH{1'b0}};
                    // on only when enabled, safe and not locked
                    if (enabled && safe && !locked && !clrCounts) begin
                        state_reg    <= S_ON;
                        passSwitchOn <= 1'b1;
                        softStartReq <= 1'b1;
                    end else if (enabled && safe && !locked) begin
                        state_reg <= S_OFF;
                    end
                end
                S_ON: begin
                    if (ovpF) begin
                        state_reg    <= S_OVP;
                        passSwitchOn <= 1'b0;
                        timer_reg    <= {TIMER_WIDTH{1'b0}};
                    end else if (!enabled) begin
                        state_reg    <= S_OFF;
                        passSwitchOn <= 1'b0;
                    end else if (batF) begin
                        state_reg    <= S_OFF;
                        passSwitchOn <= 1'b0;
                        softStopReq  <= 1'b1;
                        if (batCnt_reg != `FAULT_LIMIT)
                            batCnt_reg <= batCnt_reg + 1'b1;
                    end else if (otF) begin
                        state_reg    <= S_OFF;
                        passSwitchOn <= 1'b0;
                    end else if (ocpF) begin
                        currentLimitHold <= 1'b1;
                        if (timer_reg >= BLANK_LAST) begin
                            // off for recovery; soft stop; count
                            state_reg        <= S_OCPREC;
                            passSwitchOn     <= 1'b0;
                            softStopReq      <= 1'b1;
                            currentLimitHold <= 1'b0;
                            timer_reg        <= {TIMER_WIDTH{1'b0}};
                            if (ocpCnt_reg != `FAULT_LIMIT)
                                ocpCnt_reg <= ocpCnt_reg + 1'b1;
                        end else begin
                            timer_reg <= timer_reg + 1'b1;
                        end
                    end else begin
                        // cleared early: keep running, restart blanking
                        timer_reg <= {TIMER_WIDTH{1'b0}};
                    end
                end
                S_OVP: begin
                    // recovery deglitch restarts on each new overvoltage
                    if (ovpF) begin
                        timer_reg <= {TIMER_WIDTH{1'b0}};
                    end else if (timer_reg >= OVPREC_LAST) begin
                        timer_reg <= {TIMER_WIDTH{1'b0}};
                        state_reg <= S_OFF;
                    end else begin
                        timer_reg <= timer_reg + 1'b1;
                    end
                end
                S_OCPREC: begin
                    // off for the recovery time, then retry
                    if (timer_reg >= OCPREC_LAST) begin
                        timer_reg <= {TIMER_WIDTH{1'b0}};
                        state_reg <= S_OFF;
                    end else begin
                        timer_reg <= timer_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg    <= S_DOWN;
                    passSwitchOn <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // fault indication
    // ------------------------------------------------------------
    wire protActive = ovpF | batF | otF | locked |
                      (state_reg == S_OVP) | (state_reg == S_OCPREC);

    assign faultOut = 1'b0;

    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            faultOe <= 1'b0;
        end else begin
            // pulled low on protection or lock while enabled and above lockout
            faultOe <= ~uvlo & enabled & protActive;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    reg                  awHeld_reg;
    reg                  wHeld_reg;
    reg [ADDR_WIDTH-1:0] awAddr_reg;
    reg [31:0]           wData_reg;
    reg [3:0]            wStrb_reg;

    assign s_axi_awready = ~awHeld_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~wHeld_reg & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
    wire ctrlHit = (awAddr_reg == `REG_CTRL);

    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            awHeld_reg   <= 1'b0;
            wHeld_reg    <= 1'b0;
            awAddr_reg   <= {ADDR_WIDTH{1'b0}};
            wData_reg    <= 32'h0;
            wStrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            swClear_reg  <= 1'b0;
        end else begin
            swClear_reg <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_reg   <= 1'b0;
                wHeld_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // ctrl clear is self-clearing, so only a pulse is stored
                if (ctrlHit) begin
                    s_axi_bresp <= `RESP_OKAY;
                    swClear_reg <= wStrb_reg[0] &
                                   wData_reg[`CTRL_CLR_BIT];
                end else begin
                    s_axi_bresp <= `RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire [31:0] statusWord;
    wire [31:0] countWord;

    assign statusWord = {17'h0, state_reg, 2'h0, currentLimitHold, locked,
                         faultOe, passSwitchOn, enabled, uvlo,
                         otF, batF, ocpF, ovpF};
    assign countWord  = {20'h0, batCnt_reg, 4'h0, ocpCnt_reg};

    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            case (s_axi_araddr)
                `REG_CTRL:   s_axi_rdata <= 32'h0;
                `REG_STATUS: s_axi_rdata <= statusWord;
                `REG_COUNT:  s_axi_rdata <= countWord;
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ===== tb/charger_protect_properties.sv
// concurrent checks on the charger protection control core ports
`timescale 1ns/1ps
module charger_protect_properties #(
    parameter BLANK_CYCLES = 8
) (
    // clock and reset
    input wire ref_clk,
    input wire reset_n,
    // comparator flags and enable
    input wire inUnderVolt,
    input wire inOverVolt,
    input wire batOverVolt,
    input wire overTemp,
    input wire enable_n,
    // switch commands and fault
    input wire passSwitchOn,
    input wire softStartReq,
    input wire softStopReq,
    input wire currentLimitHold,
    input wire faultOe
);
    // current limit run length
    reg [7:0] holdCnt_reg;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            holdCnt_reg <= 8'h00;
        else if (currentLimitHold)
            holdCnt_reg <= holdCnt_reg + 8'h01;
        else
            holdCnt_reg <= 8'h00;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    // eight samples cover sync and output stages
    property p_lockoutIdle;
        inUnderVolt [*8] |-> !passSwitchOn && !faultOe;
    endproperty
    a_lockoutIdle: assert property (p_lockoutIdle)
        else $error("switch or fault active below lockout");
    property p_disabledIdle;
        enable_n [*8] |-> !passSwitchOn && !faultOe;
    endproperty
    a_disabledIdle: assert property (p_disabledIdle)
        else $error("switch or fault active while disabled");
    property p_startOnRise;
        $rose(passSwitchOn) |-> softStartReq;
    endproperty
    a_startOnRise: assert property (p_startOnRise)
        else $error("turn-on without soft start");
    property p_startOnly;
        softStartReq |-> passSwitchOn && !$past(passSwitchOn);
    endproperty
    a_startOnly: assert property (p_startOnly)
        else $error("soft start outside a turn-on");
    property p_stopOnFall;
        softStopReq |-> !passSwitchOn && $past(passSwitchOn);
    endproperty
    a_stopOnFall: assert property (p_stopOnFall)
        else $error("soft stop outside a turn-off");
    property p_ovpOff;
        inOverVolt [*8] |-> !passSwitchOn;
    endproperty
    a_ovpOff: assert property (p_ovpOff)
        else $error("switch on during input overvoltage");
    property p_faultOnFlag;
        (!enable_n && !inUnderVolt && (inOverVolt || batOverVolt || overTemp))
            [*8] |-> faultOe;
    endproperty
    a_faultOnFlag: assert property (p_faultOnFlag)
        else $error("fault not driven during protection");
    property p_blankEarly;
        currentLimitHold && holdCnt_reg < BLANK_CYCLES - 1 |-> passSwitchOn;
    endproperty
    a_blankEarly: assert property (p_blankEarly)
        else $error("switch off before blanking ran out");
    property p_blankBound;
        currentLimitHold |-> holdCnt_reg <= BLANK_CYCLES + 1;
    endproperty
    a_blankBound: assert property (p_blankBound)
        else $error("current limiting outlasted blanking");
    c_turnOn: cover property ($rose(passSwitchOn));
    c_softStop: cover property (softStopReq);
    c_blankCleared: cover property ($fell(currentLimitHold) && passSwitchOn);
endmodule

// ===== tb/charger_host_model.sv
// host side model: drives the enable pin, pulls the fault line up
`timescale 1ns/1ps
module charger_host_model (
    // clock
    input  wire ref_clk,
    // bench control
    input  wire wantDisable,
    input  wire leaveFloating,
    // device pins
    input  wire faultOe,
    input  wire faultOut,
    output wire enable_n,
    output wire faultLine
);
    reg enDrive_reg = 1'b0;
    always @(posedge ref_clk) enDrive_reg <= wantDisable;
    assign enable_n = leaveFloating ? 1'bz : enDrive_reg;
    pulldown (enable_n);
    assign faultLine = faultOe ? faultOut : 1'b1;
endmodule

// ===== tb/charger_input_protection_ctrl_test.sv
// self-checking bench for the protection control core
`timescale 1ns/1ps
`include "charger_protect_consts.vh"
module charger_input_protection_ctrl_test;
    localparam PGC = 20, OVC = 20, BLC = 8, OCC = 20;
    reg         ref_clk = 1'b0, reset_n = 1'b0, inUnderVolt = 1'b1;
    reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    reg         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    reg         s_axi_rready = 1'b0, inOverVolt = 1'b0;
    reg         inOverCurrent = 1'b0, batOverVolt = 1'b0, overTemp = 1'b0;
    reg         wantDisable = 1'b0, leaveFloating = 1'b0;
    reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg  [3:0]  s_axi_wstrb = 4'h0;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire        s_axi_arready, s_axi_rvalid, enable_n, faultLine;
    wire        passSwitchOn, softStartReq, softStopReq;
    wire        currentLimitHold, faultOe, faultOut;
    integer     fail_count = 0, checked = 0, startCnt = 0, stopCnt = 0;
    integer     holdSeen = 0, n, i;
    reg  [31:0] rd;
    reg  [1:0]  rsp;
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // short counts keep the run brief
    charger_input_protection_ctrl #(.PGOOD_CYCLES(PGC),
        .OVPREC_CYCLES(OVC), .BLANK_CYCLES(BLC), .OCPREC_CYCLES(OCC)) uut (
        .ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .inUnderVolt, .inOverVolt,
        .inOverCurrent, .batOverVolt, .overTemp, .enable_n, .passSwitchOn,
        .softStartReq, .softStopReq, .currentLimitHold, .faultOut,
        .faultOe);
    charger_host_model host (.ref_clk, .wantDisable, .leaveFloating,
        .faultOe, .faultOut, .enable_n, .faultLine);
    always @(posedge ref_clk) begin
        if (softStartReq === 1'b1)
            startCnt <= startCnt + 1;
        if (softStopReq === 1'b1)
            stopCnt <= stopCnt + 1;
        if (currentLimitHold === 1'b1)
            holdSeen <= 1;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task cyc(input integer k);
        begin
            repeat (k) @(posedge ref_clk);
            #1;
        end
    endtask
    task wait_sw(input v, input integer lim, output integer k);
        begin
            k = 0;
            while (passSwitchOn !== v && k < lim) begin
                cyc(1);
                k = k + 1;
            end
            check("switch", passSwitchOn, v);
        end
    endtask
    // code 3 marks a lost answer
    task axi_write(input [7:0] a, input [31:0] d, output [1:0] r);
        integer k;
        begin
            @(posedge ref_clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= 4'hf;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            r = 2'h3;
            for (k = 0; k < 50 && r === 2'h3; k = k + 1) begin
                @(posedge ref_clk);
                if (s_axi_awready === 1'b1)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1)
                    s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid === 1'b1) begin
                    s_axi_bready <= 1'b0;
                    r = s_axi_bresp;
                end
            end
            check("write answer", r === 2'h3, 0);
            #1;
        end
    endtask
    task axi_read(input [7:0] a, output [31:0] d, output [1:0] r);
        integer k;
        begin
            @(posedge ref_clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            r = 2'h3;
            for (k = 0; k < 50 && r === 2'h3; k = k + 1) begin
                @(posedge ref_clk);
                if (s_axi_arready === 1'b1)
                    s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid === 1'b1) begin
                    s_axi_rready <= 1'b0;
                    r = s_axi_rresp;
                    d = s_axi_rdata;
                end
            end
            check("read answer", r === 2'h3, 0);
            #1;
        end
    endtask
    task bat_fault(input back);
        begin
            @(posedge ref_clk) batOverVolt <= 1'b1;
            wait_sw(0, 10, n);
            cyc(3);
            check("fault", faultOe, 1);
            @(posedge ref_clk) batOverVolt <= 1'b0;
            wait_sw(back, 30, n);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checked %0d fail_count %0d", checked, fail_count);
            if (fail_count == 0 && checked > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        #200000;
        fail_count = fail_count + 1;
        tally_and_finish;
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        cyc(12);
        check("switch", passSwitchOn, 0);
        check("fault", faultOe, 0);
        @(posedge ref_clk) inUnderVolt <= 1'b0;
        wait_sw(1, 80, n);
        check("pgood wait", n >= PGC, 1);
        cyc(2);
        check("soft start", startCnt, 1);
        @(posedge ref_clk) inOverVolt <= 1'b1;
        wait_sw(0, 10, n);
        cyc(3);
        check("fault", faultOe, 1);
        check("fault pin", faultLine, 0);
        @(posedge ref_clk) inOverVolt <= 1'b0;
        wait_sw(1, 80, n);
        check("ovp wait", n >= OVC, 1);
        // overcurrent cleared inside blanking
        @(posedge ref_clk) inOverCurrent <= 1'b1;
        cyc(BLC - 4);
        @(posedge ref_clk) inOverCurrent <= 1'b0;
        cyc(12);
        check("limit seen", holdSeen, 1);
        check("switch", passSwitchOn, 1);
        check("no stop", stopCnt, 0);
        @(posedge ref_clk) inOverCurrent <= 1'b1;
        wait_sw(0, 30, n);
        cyc(3);
        check("soft stop", stopCnt, 1);
        check("fault", faultOe, 1);
        @(posedge ref_clk) inOverCurrent <= 1'b0;
        wait_sw(1, 80, n);
        check("ocp wait", n >= OCC - 6, 1);
        axi_read(`REG_COUNT, rd, rsp);
        check("count", rd, 32'h1);
        bat_fault(1);
        check("soft stop", stopCnt, 2);
        axi_read(`REG_COUNT, rd, rsp);
        check("count", rd, 32'h101);
        axi_read(8'h0c, rd, rsp);
        check("unmapped resp", rsp, `RESP_SLVERR);
        check("unmapped data", rd, 0);
        axi_write(`REG_STATUS, 32'h0, rsp);
        check("status write", rsp, `RESP_SLVERR);
        axi_write(`REG_CTRL, 32'h1, rsp);
        check("clear resp", rsp, `RESP_OKAY);
        axi_read(`REG_COUNT, rd, rsp);
        check("count", rd, 0);
        @(posedge ref_clk) overTemp <= 1'b1;
        wait_sw(0, 10, n);
        cyc(3);
        check("fault", faultOe, 1);
        @(posedge ref_clk) overTemp <= 1'b0;
        wait_sw(1, 20, n);
        // counts must not survive a supply drop
        bat_fault(1);
        @(posedge ref_clk) inUnderVolt <= 1'b1;
        cyc(12);
        check("switch", passSwitchOn, 0);
        check("fault", faultOe, 0);
        @(posedge ref_clk) inOverVolt <= 1'b1;
        inUnderVolt <= 1'b0;
        cyc(PGC + 20);
        check("switch", passSwitchOn, 0);
        check("fault", faultOe, 1);
        axi_read(`REG_COUNT, rd, rsp);
        check("count", rd, 0);
        @(posedge ref_clk) inOverVolt <= 1'b0;
        wait_sw(1, 80, n);
        @(posedge ref_clk) wantDisable <= 1'b1;
        inOverVolt <= 1'b1;
        cyc(12);
        check("switch", passSwitchOn, 0);
        check("fault pin", faultLine, 1);
        @(posedge ref_clk) inOverVolt <= 1'b0;
        cyc(40);
        @(posedge ref_clk) wantDisable <= 1'b0;
        wait_sw(1, 80, n);
        for (i = 0; i < 14; i = i + 1)
            bat_fault(1);
        bat_fault(0);
        cyc(40);
        check("switch", passSwitchOn, 0);
        check("fault", faultOe, 1);
        axi_read(`REG_COUNT, rd, rsp);
        check("count", rd, 32'hf00);
        @(posedge ref_clk) wantDisable <= 1'b1;
        cyc(10);
        check("fault", faultOe, 0);
        @(posedge ref_clk) leaveFloating <= 1'b1;
        wait_sw(1, 80, n);
        axi_read(`REG_COUNT, rd, rsp);
        check("count", rd, 0);
        tally_and_finish;
    end
endmodule
bind charger_input_protection_ctrl charger_protect_properties #(
    .BLANK_CYCLES(BLANK_CYCLES)
) props (.ref_clk, .reset_n, .inUnderVolt, .inOverVolt, .batOverVolt,
    .overTemp, .enable_n, .passSwitchOn, .softStartReq, .softStopReq,
    .currentLimitHold, .faultOe);
